/* dctom_monitor.sv */
// Dual-channel torque-off monitor: watches two redundant inputs, gates the power stage,
// and grades the error class by whether the channels agree within one second.
// Assumes pins come straight from the connector; fault_clear from drive logic on sys_clk.
`timescale 1ns/1ns
module dctom_monitor #(
  // Discrepancy window in cycles; a bench may shorten it to reach expiry
  parameter int unsigned DISC_CYC = dctom_pkg::DISC_WINDOW_CYC
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic torque_off_input_a,
  input wire logic torque_off_input_b,
  input wire logic fault_clear,
  input wire logic power_stage_auto_enable,
  input wire logic drive_enable_req,
  output dctom_pkg::dctom_status_t status,
  output logic brake_active
);
  logic [1:0] pins_sync;
  logic ch_a_ok;
  logic ch_b_ok;
  logic any_off;
  logic all_off;
  logic all_ok;
  dctom_pkg::dctom_state_t state_ff;
  dctom_pkg::dctom_state_t nxt_state;
  logic [dctom_pkg::CNT_W-1:0] cnt_ff;
  logic [dctom_pkg::CNT_W-1:0] nxt_cnt;
  logic [2:0] class_ff;
  logic [2:0] nxt_class;
  logic enable_ff;
  logic nxt_enable;
  logic [dctom_pkg::CNT_W-1:0] wait_age_ff;
  logic [dctom_pkg::CNT_W-1:0] nxt_wait_age;

  // Last counter value inside the window, and the full window length
  localparam logic [dctom_pkg::CNT_W-1:0] WIN_LAST = dctom_pkg::CNT_W'(DISC_CYC - 1);
  localparam logic [dctom_pkg::CNT_W-1:0] WIN_LEN = dctom_pkg::CNT_W'(DISC_CYC);

  // Window end test, shared by the state logic and its checks
  function automatic logic window_done(input logic [dctom_pkg::CNT_W-1:0] cnt);
    return cnt >= WIN_LAST;
  endfunction

  // Pins cross into sys_clk domain through two flops
  dctom_sync u_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .pin_in({torque_off_input_b, torque_off_input_a}),
    .pin_sync(pins_sync)
  );

  // Positive logic: high permits operation, low requests removal
  assign ch_a_ok = pins_sync[0];
  assign ch_b_ok = pins_sync[1];
  assign any_off = !ch_a_ok || !ch_b_ok;
  assign all_off = !ch_a_ok && !ch_b_ok;
  assign all_ok = ch_a_ok && ch_b_ok;

  // Monitor state, discrepancy counter and error class
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_class = class_ff;
    case (state_ff)
      dctom_pkg::DCTOM_RUN: begin
        nxt_cnt = dctom_pkg::CNT_RST;
        if (all_off) begin
          nxt_state = dctom_pkg::DCTOM_BOTH_OFF;
          nxt_class = dctom_pkg::ERR_CLASS_STOP;
        end else if (any_off) begin
          nxt_state = dctom_pkg::DCTOM_WAIT_SECOND;
          nxt_class = dctom_pkg::ERR_CLASS_STOP;
        end
      end
      dctom_pkg::DCTOM_WAIT_SECOND: begin
        if (all_off) begin
          nxt_state = dctom_pkg::DCTOM_BOTH_OFF;
        end else if (window_done(cnt_ff)) begin
          nxt_state = dctom_pkg::DCTOM_DISCREPANT;
          nxt_class = dctom_pkg::ERR_CLASS_DISC;
        end else begin
          nxt_cnt = cnt_ff + 27'h000_0001;
        end
      end
      dctom_pkg::DCTOM_BOTH_OFF, dctom_pkg::DCTOM_DISCREPANT: begin
        // Latched until both inputs high and an explicit clear
        if (all_ok && fault_clear) begin
          nxt_state = dctom_pkg::DCTOM_RUN;
          nxt_class = dctom_pkg::ERR_CLASS_NONE;
          nxt_cnt = dctom_pkg::CNT_RST;
        end
      end
      default: begin
        nxt_state = dctom_pkg::DCTOM_BOTH_OFF;
        nxt_class = dctom_pkg::ERR_CLASS_DISC;
      end
    endcase
  end

  // Power stage enable; dropped the cycle after any channel reads low
  always_comb begin
    nxt_enable = 1'b0;
    if (nxt_state == dctom_pkg::DCTOM_RUN && !any_off) begin
      nxt_enable = drive_enable_req && (enable_ff || power_stage_auto_enable);
    end
  end

  // Register state, counter, class and enable
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_ff <= dctom_pkg::DCTOM_RUN;
      cnt_ff <= dctom_pkg::CNT_RST;
      class_ff <= dctom_pkg::ERR_CLASS_NONE;
      enable_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      class_ff <= nxt_class;
      enable_ff <= nxt_enable;
    end
  end

  // Check-only age of the wait state, kept apart from the design counter
  always_comb begin
    nxt_wait_age = dctom_pkg::CNT_RST;
    if (state_ff == dctom_pkg::DCTOM_WAIT_SECOND) begin
      nxt_wait_age = wait_age_ff + 27'h000_0001;
    end
  end

  // Register the wait age
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wait_age_ff <= dctom_pkg::CNT_RST;
    end else begin
      wait_age_ff <= nxt_wait_age;
    end
  end

  // Outputs from flops; no active braking at all
  assign status.power_stage_enable = enable_ff;
  assign status.torque_off_active = (state_ff != dctom_pkg::DCTOM_RUN);
  assign status.error_class = class_ff;
  assign status.fault_latched = (state_ff == dctom_pkg::DCTOM_BOTH_OFF) ||
                                (state_ff == dctom_pkg::DCTOM_DISCREPANT);
  assign brake_active = 1'b0;

  // Any low channel gives class 3 and a dead stage next cycle
  AST_STOP_CLASS3: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state_ff == dctom_pkg::DCTOM_RUN && any_off) |=>
      (class_ff == dctom_pkg::ERR_CLASS_STOP && !enable_ff))
    else $error("torque off did not give class 3 with stage off");

  // Second channel following keeps class 3
  AST_KEEP_CLASS3: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state_ff == dctom_pkg::DCTOM_WAIT_SECOND && all_off) |=>
      (class_ff == dctom_pkg::ERR_CLASS_STOP && state_ff == dctom_pkg::DCTOM_BOTH_OFF))
    else $error("class changed though second channel followed");

  // Window expiry raises class to 4
  AST_ESCALATE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state_ff == dctom_pkg::DCTOM_WAIT_SECOND && !all_off && window_done(cnt_ff)) |=>
      (class_ff == dctom_pkg::ERR_CLASS_DISC))
    else $error("discrepancy did not escalate to class 4");

  // No escalation before the window ends
  AST_NO_EARLY: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(class_ff == dctom_pkg::ERR_CLASS_DISC) |->
      $past(cnt_ff) == WIN_LAST)
    else $error("class 4 raised before one second");

  // Low pin reaches stage within synchroniser plus one register
  AST_PIN_TO_STAGE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!torque_off_input_a || !torque_off_input_b) |-> ##3 !enable_ff)
    else $error("low pin did not drop power stage");

  // Never brake, never enable while torque off
  AST_COAST: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !brake_active && !(enable_ff && status.torque_off_active))
    else $error("torque or braking during torque off");

  // Latched until inputs high and clear
  AST_LATCH: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (status.fault_latched && !(all_ok && fault_clear)) |=>
      (status.fault_latched && $stable(class_ff) && !enable_ff))
    else $error("fault released without clear");

  // Clear with both high returns to run with class cleared
  AST_CLEAR: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (status.fault_latched && all_ok && fault_clear) |=>
      (state_ff == dctom_pkg::DCTOM_RUN && class_ff == dctom_pkg::ERR_CLASS_NONE))
    else $error("clear did not release fault");

  // Both channels low together go straight to the both-off state
  AST_BOTH_DIRECT: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state_ff == dctom_pkg::DCTOM_RUN && all_off) |=>
      (state_ff == dctom_pkg::DCTOM_BOTH_OFF && class_ff == dctom_pkg::ERR_CLASS_STOP))
    else $error("both channels low did not give class 3");

  // Class agrees with state: none only in run, 4 only when discrepant
  AST_CLASS_STATE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ((class_ff == dctom_pkg::ERR_CLASS_NONE) == (state_ff == dctom_pkg::DCTOM_RUN)) &&
    ((class_ff == dctom_pkg::ERR_CLASS_DISC) == (state_ff == dctom_pkg::DCTOM_DISCREPANT)))
    else $error("error class out of step with state");

  // Counter steps by one and class stays 3 while the window is open
  AST_WINDOW_COUNT: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state_ff == dctom_pkg::DCTOM_WAIT_SECOND && !all_off && !window_done(cnt_ff)) |=>
      (state_ff == dctom_pkg::DCTOM_WAIT_SECOND && class_ff == dctom_pkg::ERR_CLASS_STOP &&
       cnt_ff == $past(cnt_ff) + 27'h000_0001))
    else $error("window count or class wrong while waiting");

  // Class 4 comes exactly one full window after the wait began
  AST_WINDOW_LEN: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(class_ff == dctom_pkg::ERR_CLASS_DISC) |-> (wait_age_ff == WIN_LEN))
    else $error("class 4 not one window after first channel");

  // Stage comes up only on request with auto enable and both channels high
  AST_ENABLE_RISE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(enable_ff) |->
      ($past(drive_enable_req) && $past(power_stage_auto_enable) && $past(all_ok)))
    else $error("power stage enabled without request or with a channel low");
endmodule

/* dctom_pkg.sv */
// Package for the dual-channel torque-off monitor: timing, error classes, carriers.
// Assumes a 100 MHz system clock; no imports, every use is scoped.
package dctom_pkg;
  // Clock period in ns
  localparam int unsigned CLK_PERIOD_NS = 10;
  // Discrepancy window, one second in ms
  localparam int unsigned DISC_WINDOW_MS = 1000;
  // Window in cycles, longest time so rounded down
  localparam int unsigned DISC_WINDOW_CYC = (DISC_WINDOW_MS * 1000000) / CLK_PERIOD_NS;
  // Counter width
  localparam int unsigned CNT_W = 27;
  // Error class codes
  localparam logic [2:0] ERR_CLASS_NONE = 3'h0;
  localparam logic [2:0] ERR_CLASS_STOP = 3'h3;
  localparam logic [2:0] ERR_CLASS_DISC = 3'h4;
  // Reset values
  localparam logic [CNT_W-1:0] CNT_RST = 27'h000_0000;
  localparam logic [1:0] SYNC_RST = 2'h3;

  // Monitor states
  typedef enum logic [1:0] {
    DCTOM_RUN,
    DCTOM_WAIT_SECOND,
    DCTOM_BOTH_OFF,
    DCTOM_DISCREPANT
  } dctom_state_t;

  // Status carried to the drive
  typedef struct packed {
    logic power_stage_enable;
    logic torque_off_active;
    logic [2:0] error_class;
    logic fault_latched;
  } dctom_status_t;
endpackage

/* dctom_sync.sv */
// Two-flop synchroniser for the two torque-off pins.
// Assumes asynchronous pin levels; reset value is the high (operate) level.
`timescale 1ns/1ns
module dctom_sync (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [1:0] pin_in,
  output logic [1:0] pin_sync
);
  logic [1:0] stage1_ff;
  logic [1:0] stage2_ff;
  logic [1:0] nxt_stage1;
  logic [1:0] nxt_stage2;

  // Next values of the chain
  always_comb begin
    nxt_stage1 = pin_in;
    nxt_stage2 = stage1_ff;
  end

  // Register stage, synchronous reset
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      stage1_ff <= dctom_pkg::SYNC_RST;
      stage2_ff <= dctom_pkg::SYNC_RST;
    end else begin
      stage1_ff <= nxt_stage1;
      stage2_ff <= nxt_stage2;
    end
  end

  assign pin_sync = stage2_ff;
endmodule

/* dctom_estop_model.sv */
// Model of an emergency-stop switch with two contacts that open with a skew.
// Assumes press, first_b and skew are driven by the bench on sys_clk.
`timescale 1ns/1ns
module dctom_estop_model (
  input wire logic sys_clk,
  input wire logic press,
  input wire logic first_b,
  input wire logic [7:0] skew,
  output logic torque_off_input_a,
  output logic torque_off_input_b
);
  logic [7:0] lag_ff = 8'h00;
  // Counts cycles since press, stops at the skew
  always @(posedge sys_clk) begin
    lag_ff <= !press ? 8'h00 : (lag_ff == skew) ? lag_ff : lag_ff + 8'h01;
  end
  // Leading contact opens at once, trailing one after skew; low means stop
  assign torque_off_input_a = !(press && (!first_b || lag_ff == skew));
  assign torque_off_input_b = !(press && (first_b || lag_ff == skew));
endmodule

/* dual_channel_torque_off_monitor_tb.sv */
// Self-checking bench: random stop, clear and restart trials on the monitor.
// Assumes the monitor and the switch model are compiled before it.
`timescale 1ns/1ns
module dual_channel_torque_off_monitor_tb;
  // Shortened discrepancy window so that expiry is reached in the run
  localparam int unsigned WIN_CYC = 40;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic press = 1'b0;
  logic first_b = 1'b0;
  logic [7:0] skew = 8'h00;
  logic fault_clear = 1'b0;
  logic auto_en = 1'b0;
  logic enable_req = 1'b0;
  logic pin_a;
  logic pin_b;
  logic brake_active;
  dctom_pkg::dctom_status_t status;
  int bad_count = 0;
  int checks_done = 0;
  int seed = 67;
  int n;
  // Clock, 10 ns period
  always #5 sys_clk = ~sys_clk;
  dctom_estop_model i_estop (.sys_clk(sys_clk), .press(press), .first_b(first_b),
    .skew(skew), .torque_off_input_a(pin_a), .torque_off_input_b(pin_b));
  dctom_monitor #(.DISC_CYC(WIN_CYC)) i_dut (.sys_clk(sys_clk), .rst_n(rst_n),
    .torque_off_input_a(pin_a),
    .torque_off_input_b(pin_b), .fault_clear(fault_clear),
    .power_stage_auto_enable(auto_en), .drive_enable_req(enable_req),
    .status(status), .brake_active(brake_active));
  // Expected class: none when running, 3 on a stop, 4 when the lag outlasts the window
  function automatic logic [2:0] exp_class(input logic stopped, input int lag);
    if (!stopped) return dctom_pkg::ERR_CLASS_NONE;
    return (lag > int'(WIN_CYC)) ? dctom_pkg::ERR_CLASS_DISC : dctom_pkg::ERR_CLASS_STOP;
  endfunction
  task automatic check(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("MISMATCH at %0t: %s", $time, msg);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Bounded wait for masked status bits
  task automatic wait_status(input logic [5:0] mask, input logic [5:0] want, input string msg);
    int k;
    for (k = 0; k < 20; k++) begin
      @(posedge sys_clk);
      #1;
      if ((status & mask) === want) return;
    end
    check(1'b0, msg);
    tally_and_finish();
  endtask
  // Main sequence
  initial begin
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    enable_req <= 1'b1;
    auto_en <= 1'b1;
    #1 check(status === 6'h00 && brake_active === 1'b0, "reset state");
    wait_status(6'h20, 6'h20, "enable with pins high");
    $display("reset test done");
    for (n = 0; n < 12; n++) begin
      @(posedge sys_clk);
      if (n == 0) skew <= 8'h00;
      else if (n == 1) skew <= 8'(WIN_CYC + 5);
      else if (n == 2) skew <= 8'(WIN_CYC);
      else skew <= 8'($unsigned($random(seed)) % 60);
      first_b <= 1'($random(seed));
      press <= 1'b1;
      wait_status(6'h10, 6'h10, "no stop");
      check(!status.power_stage_enable && status.error_class === exp_class(1'b1, 0),
        "stop");
      check(brake_active === 1'b0, "braking");
      repeat (WIN_CYC + 8) @(posedge sys_clk);
      #1 check(status.error_class === exp_class(1'b1, int'(skew)) &&
        status.fault_latched === 1'b1, "second");
      @(posedge sys_clk);
      fault_clear <= 1'b1;
      @(posedge sys_clk);
      fault_clear <= 1'b0;
      press <= 1'b0;
      auto_en <= 1'($random(seed));
      repeat (4) @(posedge sys_clk);
      #1 check(status.error_class === exp_class(1'b1, int'(skew)) &&
        !status.power_stage_enable, "held");
      @(posedge sys_clk);
      fault_clear <= 1'b1;
      @(posedge sys_clk);
      fault_clear <= 1'b0;
      wait_status(6'h1f, 6'h00, "no clear");
      if (auto_en === 1'b0) begin
        repeat (5) @(posedge sys_clk);
        #1 check(status.power_stage_enable === 1'b0, "auto off restart");
      end
      @(posedge sys_clk);
      auto_en <= 1'b1;
      wait_status(6'h20, 6'h20, "no restart");
      $display("trial %0d done", n);
    end
    // Reset in mid-run with the stop still pressed: the stop is seen again
    @(posedge sys_clk);
    skew <= 8'h00;
    press <= 1'b1;
    wait_status(6'h10, 6'h10, "no stop before reset");
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    #1 check(status === 6'h00 && brake_active === 1'b0, "mid-run reset state");
    wait_status(6'h1e, 6'h16, "stop lost over reset");
    $display("mid-run reset test done");
    tally_and_finish();
  end
endmodule
